// ---- common/sub_exec_pkg.sv ----
/*
 * Constants and carrier types for the subtract execution block:
 * register offsets, field positions, opcode patterns, addressing limits.
 * Assumes a 32-bit AHB-Lite register bus and an 8-bit banked data memory
 * with a 12-bit address outside the block.
 */
package sub_exec_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0] OFS_OPCODE = 8'h00;
   localparam logic [7:0] OFS_ACCUM = 8'h04;
   localparam logic [7:0] OFS_BANK = 8'h08;
   localparam logic [7:0] OFS_CONFIG = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_INDEX = 8'h14;
   localparam logic [7:0] OFS_LAST_ADDR = 8'h18;
   localparam int REG_ADDR_W = 8;

   // Status and config register bit positions
   localparam int ST_C = 0;
   localparam int ST_DCARRY = 1;
   localparam int ST_Z = 2;
   localparam int ST_OVF = 3;
   localparam int ST_N = 4;
   localparam int ST_BUSY = 8;
   localparam int ST_ILLEGAL = 9;
   localparam int ST_DROPPED = 10;
   localparam int CFG_EXT = 0;

   // Opcode fields and patterns
   localparam logic [7:0] LIT_OPCODE = 8'h08;
   localparam logic [5:0] REG_OPCODE = 6'h17;
   localparam int DEST_BIT = 9;
   localparam int BANK_BIT = 8;

   // Addressing limits and pages
   localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hF;

   // Reset values
   localparam logic [15:0] OPCODE_RST = 16'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [3:0] BANK_RST = 4'h0;
   localparam logic [11:0] ADDR_RST = 12'h000;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // Arithmetic flags
   typedef struct packed {
      logic neg;
      logic ovf;
      logic zero;
      logic dcarry;
      logic carry;
   } flags_t;

   // Request to the banked data memory
   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [7:0] wdata;
   } mem_req_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_Q1,
      ST_Q2,
      ST_Q3,
      ST_Q4
   } phase_t;

endpackage

// ---- rtl/sub_exec.sv ----
/*
 * Execution unit for the two 8-bit subtract instructions: literal minus
 * accumulator, and register minus accumulator with a selectable destination.
 * Software loads opcodes and state over AHB-Lite; each instruction runs in
 * four quarter-phases of one hclk cycle each.
 * Assumes the data memory answers a read strobe with data in the next cycle
 * and takes a write strobe in the cycle it is high.
 */
// Functional notes
// - Literal op computes literal minus accumulator.
// - Literal op writes accumulator, four cycles.
// - Register op computes register minus accumulator.
// - Destination bit picks accumulator or register.
// - Bank bit picks access bank or bank select.
// - Extended set, access-bank low addresses use indexed offset.
// - Register op: decode, read, compute, write.
// - Literal op: decode, take literal, compute, write.
`timescale 1ns/100ps

module sub_exec (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [1:0] hresp,
   output logic [31:0] hrdata,
   // Banked data memory
   output sub_exec_pkg::mem_req_t mem_req,
   input wire logic [7:0] mem_rdata,
   // Completion
   output logic exec_done
);
   import sub_exec_pkg::*;

   phase_t state_q;
   logic [15:0] opcode_q;
   logic [7:0] accum_q;
   logic [3:0] bank_q;
   logic ext_q;
   logic [11:0] index_q;
   logic [11:0] last_addr_q;
   flags_t flags_q;
   flags_t flags_d;
   logic illegal_q;
   logic dropped_q;
   logic [7:0] result_q;
   logic [7:0] result_d;
   logic dest_reg_q;
   logic wr_pend_q;
   logic [REG_ADDR_W-1:0] wr_addr_q;
   logic [7:0] operand;
   logic [8:0] diff9;
   logic [4:0] diff5;
   logic is_lit;
   logic is_reg;
   logic busy;
   logic wr_en;
   logic rd_en;
   logic [11:0] eff_addr;
   logic [31:0] rd_mux;

   // Opcode class decode
   assign is_lit = (opcode_q[15:8] == LIT_OPCODE);
   assign is_reg = (opcode_q[15:10] == REG_OPCODE);
   assign busy = (state_q != ST_IDLE);

   // Bus phases: write lands in the data phase, reads answered at once
   assign rd_en = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite;
   assign wr_en = wr_pend_q;

   // Address phase capture for writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
      end else if (hready) begin
         wr_pend_q <= hsel && (htrans == HTRANS_NONSEQ) && hwrite;
         wr_addr_q <= haddr[REG_ADDR_W-1:0];
      end
   end

   // Read mux; unmapped offsets read as zero
   always_comb begin
      rd_mux = WORD_ZERO;
      if (haddr[REG_ADDR_W-1:0] == OFS_OPCODE) begin
         rd_mux[15:0] = opcode_q;
      end else if (haddr[REG_ADDR_W-1:0] == OFS_ACCUM) begin
         rd_mux[7:0] = accum_q;
      end else if (haddr[REG_ADDR_W-1:0] == OFS_BANK) begin
         rd_mux[3:0] = bank_q;
      end else if (haddr[REG_ADDR_W-1:0] == OFS_CONFIG) begin
         rd_mux[CFG_EXT] = ext_q;
      end else if (haddr[REG_ADDR_W-1:0] == OFS_STATUS) begin
         rd_mux[ST_C] = flags_q.carry;
         rd_mux[ST_DCARRY] = flags_q.dcarry;
         rd_mux[ST_Z] = flags_q.zero;
         rd_mux[ST_OVF] = flags_q.ovf;
         rd_mux[ST_N] = flags_q.neg;
         rd_mux[ST_BUSY] = busy;
         rd_mux[ST_ILLEGAL] = illegal_q;
         rd_mux[ST_DROPPED] = dropped_q;
      end else if (haddr[REG_ADDR_W-1:0] == OFS_INDEX) begin
         rd_mux[11:0] = index_q;
      end else if (haddr[REG_ADDR_W-1:0] == OFS_LAST_ADDR) begin
         rd_mux[11:0] = last_addr_q;
      end
   end

   // Read data registered so it stands for the whole data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= WORD_ZERO;
      end else if (rd_en) begin
         hrdata <= rd_mux;
      end
   end

   // Zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end
   end

   // Operand address: bank select, indexed offset or access bank
   always_comb begin
      if (opcode_q[BANK_BIT]) begin
         eff_addr = {bank_q, opcode_q[7:0]};
      end else if (ext_q && (opcode_q[7:0] <= ACCESS_LIMIT)) begin
         eff_addr = index_q + {4'h0, opcode_q[7:0]};
      end else if (opcode_q[7:0] <= ACCESS_LIMIT) begin
         eff_addr = {ACCESS_LOW_PAGE, opcode_q[7:0]};
      end else begin
         eff_addr = {ACCESS_HIGH_PAGE, opcode_q[7:0]};
      end
   end

   // Subtrahend is always the accumulator; borrow-free gives carry high
   assign operand = is_lit ? opcode_q[7:0] : mem_rdata;
   assign diff9 = {1'b0, operand} + {1'b0, ~accum_q} + 9'h001;
   assign diff5 = {1'b0, operand[3:0]} + {1'b0, ~accum_q[3:0]} + 5'h01;
   assign result_d = diff9[7:0];

   // Flag derivation from the two's complement difference
   always_comb begin
      flags_d.carry = diff9[8];
      flags_d.dcarry = diff5[4];
      flags_d.ovf = (operand[7] != accum_q[7]) && (result_d[7] != operand[7]);
      flags_d.zero = (result_d == BYTE_RST);
      flags_d.neg = result_d[7];
   end

   // Quarter-phase sequencer, one hclk per phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (wr_en && (wr_addr_q == OFS_OPCODE)) begin
                  state_q <= ST_Q1;
               end
            end
            ST_Q1: begin
               // Unknown opcodes stop at decode
               state_q <= (is_lit || is_reg) ? ST_Q2 : ST_IDLE;
            end
            ST_Q2: state_q <= ST_Q3;
            ST_Q3: state_q <= ST_Q4;
            ST_Q4: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Opcode latch; a write while busy would corrupt the running decode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opcode_q <= OPCODE_RST;
      end else if (wr_en && (wr_addr_q == OFS_OPCODE) && !busy) begin
         opcode_q <= hwdata[15:0];
      end
   end

   // Destination decision made in the decode phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dest_reg_q <= 1'b0;
      end else if (state_q == ST_Q1) begin
         dest_reg_q <= is_reg && opcode_q[DEST_BIT];
      end
   end

   // Result and flags taken in the compute phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result_q <= BYTE_RST;
      end else if (state_q == ST_Q3) begin
         result_q <= result_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_q <= '0;
      end else if (state_q == ST_Q3) begin
         flags_q <= flags_d;
      end
   end

   // Accumulator: written in the last phase, else by software when idle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         accum_q <= BYTE_RST;
      end else if ((state_q == ST_Q4) && !dest_reg_q) begin
         accum_q <= result_q;
      end else if (wr_en && (wr_addr_q == OFS_ACCUM) && !busy) begin
         accum_q <= hwdata[7:0];
      end
   end

   // Memory strobes: read during the read phase, write during the last
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_req <= '0;
      end else begin
         mem_req.rd <= (state_q == ST_Q1) && is_reg;
         mem_req.wr <= (state_q == ST_Q3) && dest_reg_q;
         mem_req.wdata <= (state_q == ST_Q3) ? result_d : BYTE_RST;
         if (state_q == ST_Q1) begin
            mem_req.addr <= eff_addr;
         end
      end
   end

   // Last operand address, kept for software inspection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_addr_q <= ADDR_RST;
      end else if ((state_q == ST_Q1) && is_reg) begin
         last_addr_q <= eff_addr;
      end
   end

   // Bank select, extended mode and index base: software only, idle only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bank_q <= BANK_RST;
      end else if (wr_en && (wr_addr_q == OFS_BANK) && !busy) begin
         bank_q <= hwdata[3:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_q <= 1'b0;
      end else if (wr_en && (wr_addr_q == OFS_CONFIG) && !busy) begin
         ext_q <= hwdata[CFG_EXT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         index_q <= ADDR_RST;
      end else if (wr_en && (wr_addr_q == OFS_INDEX) && !busy) begin
         index_q <= hwdata[11:0];
      end
   end

   // Sticky error bits: write one to clear, a new event wins the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         illegal_q <= 1'b0;
      end else if ((state_q == ST_Q1) && !is_lit && !is_reg) begin
         illegal_q <= 1'b1;
      end else if (wr_en && (wr_addr_q == OFS_STATUS) && hwdata[ST_ILLEGAL]) begin
         illegal_q <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dropped_q <= 1'b0;
      end else if (wr_en && busy && (wr_addr_q != OFS_STATUS)) begin
         dropped_q <= 1'b1;
      end else if (wr_en && (wr_addr_q == OFS_STATUS) && hwdata[ST_DROPPED]) begin
         dropped_q <= 1'b0;
      end
   end

   // One-cycle completion pulse after the write phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         exec_done <= 1'b0;
      end else begin
         exec_done <= (state_q == ST_Q4);
      end
   end

endmodule

// ---- verification/sub_exec_assertions.sv ----
/* Port-level checker for sub_exec.
   Assumes one clock domain; bound to the design top at the foot. */
`timescale 1ns/100ps
module sub_exec_assertions (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Watched outputs
   input wire logic hreadyout,
   input wire logic [1:0] hresp,
   input wire sub_exec_pkg::mem_req_t mem_req,
   input wire logic exec_done
);
   import sub_exec_pkg::*;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // Read strobe, two quiet phases, then completion
   sequence s_after_read;
      !mem_req.rd ##1 !mem_req.rd ##1 exec_done;
   endsequence
   property p_reg_walk; mem_req.rd |=> s_after_read; endproperty
   property p_wr_after_rd; mem_req.wr |-> $past(mem_req.rd, 2) && $stable(mem_req.addr); endproperty
   property p_addr_hold; mem_req.rd |=> $stable(mem_req.addr) [*3]; endproperty
   property p_wr_pulse; mem_req.wr |=> !mem_req.wr && exec_done; endproperty
   property p_done_pulse; exec_done |=> !exec_done; endproperty
   property p_no_overlap; !(mem_req.rd && mem_req.wr); endproperty
   property p_done_quiet; exec_done |-> !mem_req.rd && !mem_req.wr; endproperty
   property p_ready; $past(hresetn) |-> hreadyout && hresp == HRESP_OKAY; endproperty
   a_reg_walk: assert property (p_reg_walk) else $error("register op phases out of order");
   a_wr_after_rd: assert property (p_wr_after_rd) else $error("write without matching read");
   a_addr_hold: assert property (p_addr_hold) else $error("operand address moved");
   a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe not one cycle");
   a_done_pulse: assert property (p_done_pulse) else $error("done not one cycle");
   a_no_overlap: assert property (p_no_overlap) else $error("read and write together");
   a_done_quiet: assert property (p_done_quiet) else $error("strobe during done");
   a_ready: assert property (p_ready) else $error("bus not ready or not okay");
endmodule

bind sub_exec sub_exec_assertions i_sub_exec_assertions (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req), .exec_done(exec_done));

// ---- verification/data_mem_model.sv ----
/* Behavioural banked data memory.
   Assumes read data wanted the cycle after a read strobe. */
`timescale 1ns/100ps
module data_mem_model (
   // Clock
   input wire logic hclk,
   // Request and answer
   input wire sub_exec_pkg::mem_req_t mem_req,
   output logic [7:0] mem_rdata
);
   import sub_exec_pkg::*;
   logic [7:0] cells [0:4095];
   initial mem_rdata = 8'h00;
   // Data stands one cycle; then it toggles so a late sample shows
   always @(posedge hclk) begin
      if (mem_req.rd)
         mem_rdata <= cells[mem_req.addr];
      else
         mem_rdata <= ~mem_rdata;
      if (mem_req.wr)
         cells[mem_req.addr] <= mem_req.wdata;
   end
endmodule

// ---- verification/tb_sub_exec.sv ----
/* Self-checking bench for sub_exec with queued expectations.
   Assumes a zero-wait slave and the memory model beside it. */
`timescale 1ns/100ps
module tb_sub_exec;
   import sub_exec_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   wire hready;
   logic hreadyout;
   logic [1:0] hresp;
   logic [31:0] hrdata;
   mem_req_t mem_req;
   logic [7:0] mem_rdata;
   logic exec_done;
   logic rd_pend = 1'b0;
   logic [31:0] seed = 32'h0001_65F9;
   int n_fail = 0;
   int num_checks = 0;
   logic [31:0] exp_q [$];
   logic [19:0] wr_q [$];
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   sub_exec i_sub_exec (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req), .mem_rdata(mem_rdata), .exec_done(exec_done));
   data_mem_model i_data_mem_model (.hclk(hclk), .mem_req(mem_req), .mem_rdata(mem_rdata));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected status word for a minus b; carry means no borrow
   function automatic logic [31:0] status(logic [7:0] a, logic [7:0] b);
      logic [7:0] r;
      r = a - b;
      status = WORD_ZERO;
      status[ST_C] = a >= b;
      status[ST_DCARRY] = a[3:0] >= b[3:0];
      status[ST_Z] = r == 8'h00;
      status[ST_OVF] = a[7] != b[7] && r[7] != a[7];
      status[ST_N] = r[7];
   endfunction

   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Bounded wait for ready; a hang counts as a mismatch
   task automatic bus_wait();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) begin
         n_fail++;
         stop_test();
      end
   endtask

   task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      bus_wait();
      htrans <= 2'h0;
      hwdata <= wr ? d : WORD_ZERO;
      bus_wait();
   endtask

   task automatic rd(logic [7:0] a, logic [31:0] exp);
      exp_q.push_back(exp);
      xfer(1'b0, a, WORD_ZERO);
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      while (exec_done !== 1'b1 && n < 20) begin
         @(posedge hclk);
         #1;
         n++;
      end
      if (n >= 20) begin
         n_fail++;
         stop_test();
      end
   endtask

   // Monitor: read data and memory writes against the oldest note
   always @(posedge hclk) begin
      if (rd_pend)
         check("read data", exp_q.pop_front(), hrdata);
      if (mem_req.wr === 1'b1)
         check("memory write", {12'h000, wr_q.pop_front()}, {12'h000, mem_req.addr, mem_req.wdata});
      rd_pend <= hsel && htrans == HTRANS_NONSEQ && !hwrite && hready;
   end

   initial begin
      logic [31:0] r32, st;
      logic [7:0] k, w, f;
      logic [3:0] bk;
      logic [11:0] idx, ad;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      rd(OFS_STATUS, WORD_ZERO);
      rd(8'h1C, WORD_ZERO);
      $display("test reset done");
      // Literal op: worked cases first, then random operands
      for (int i = 0; i < 12; i++) begin
         r32 = rnd();
         k = i < 3 ? 8'h02 : r32[7:0];
         w = i < 3 ? 8'(i + 1) : r32[15:8];
         xfer(1'b1, OFS_ACCUM, {24'h00_0000, w});
         xfer(1'b1, OFS_OPCODE, {16'h0000, LIT_OPCODE, k});
         wait_done();
         rd(OFS_ACCUM, {24'h00_0000, k - w});
         rd(OFS_STATUS, status(k, w));
      end
      $display("test literal done");
      // Register op over every d, a and extended-set mix, both address ranges
      for (int i = 0; i < 16; i++) begin
         r32 = rnd();
         k = r32[7:0];
         w = r32[15:8];
         f = i == 15 ? 8'h5F : i == 7 ? 8'h60 : i[3] ? r32[23:16] & 8'h5F : r32[23:16] | 8'h60;
         bk = r32[27:24];
         r32 = rnd();
         idx = r32[11:0];
         ad = i[1] ? {bk, f} : (i[2] && f <= ACCESS_LIMIT) ? idx + {4'h0, f} :
            f <= ACCESS_LIMIT ? {ACCESS_LOW_PAGE, f} : {ACCESS_HIGH_PAGE, f};
         i_data_mem_model.cells[ad] = k;
         xfer(1'b1, OFS_CONFIG, {31'h0000_0000, i[2]});
         xfer(1'b1, OFS_BANK, {28'h000_0000, bk});
         xfer(1'b1, OFS_INDEX, {20'h0_0000, idx});
         xfer(1'b1, OFS_ACCUM, {24'h00_0000, w});
         if (i[0])
            wr_q.push_back({ad, k - w});
         xfer(1'b1, OFS_OPCODE, {16'h0000, REG_OPCODE, i[0], i[1], f});
         wait_done();
         rd(OFS_ACCUM, {24'h00_0000, i[0] ? w : k - w});
         st = status(k, w);
         rd(OFS_STATUS, st);
         rd(OFS_LAST_ADDR, {20'h0_0000, ad});
      end
      $display("test register done");
      // Unknown opcode leaves flags alone and sets a sticky bit
      xfer(1'b1, OFS_OPCODE, 32'h0000_FFFF);
      repeat (4) @(posedge hclk);
      rd(OFS_STATUS, st | (32'h0000_0001 << ST_ILLEGAL));
      xfer(1'b1, OFS_STATUS, 32'h0000_0001 << ST_ILLEGAL);
      rd(OFS_STATUS, st);
      rd(OFS_OPCODE, 32'h0000_FFFF);
      rd(OFS_BANK, {28'h000_0000, bk});
      rd(OFS_INDEX, {20'h0_0000, idx});
      rd(OFS_CONFIG, 32'h0000_0001);
      $display("test illegal done");
      // Busy shows during a run; a register write in that time is refused and noted
      xfer(1'b1, OFS_ACCUM, 32'h0000_0003);
      xfer(1'b1, OFS_OPCODE, {16'h0000, LIT_OPCODE, 8'h07});
      rd(OFS_STATUS, st | (32'h0000_0001 << ST_BUSY));
      wait_done();
      rd(OFS_ACCUM, 32'h0000_0004);
      xfer(1'b1, OFS_OPCODE, {16'h0000, LIT_OPCODE, 8'h07});
      xfer(1'b1, OFS_ACCUM, 32'h0000_00AA);
      wait_done();
      rd(OFS_ACCUM, 32'h0000_0003);
      rd(OFS_STATUS, status(8'h07, 8'h04) | (32'h0000_0001 << ST_DROPPED));
      xfer(1'b1, OFS_STATUS, 32'h0000_0001 << ST_DROPPED);
      rd(OFS_STATUS, status(8'h07, 8'h04));
      $display("test busy done");
      stop_test();
   end
endmodule
